//--- hw/drw_pkg.sv
// package: register indices, field positions and address limits of the display ram writer
package drw_pkg;
  // register indices as seen on the host index port
  localparam logic [3:0] IDX_CONTROL_ONE = 4'h0;
  localparam logic [3:0] IDX_DATA_ACCESS_CONTROL = 4'h5;
  localparam logic [3:0] IDX_X_POINTER = 4'h6;
  localparam logic [3:0] IDX_Y_POINTER = 4'h7;
  localparam logic [3:0] IDX_WINDOW_X_MIN = 4'h8;
  localparam logic [3:0] IDX_WINDOW_X_MAX = 4'h9;
  localparam logic [3:0] IDX_WINDOW_Y_MIN = 4'hA;
  localparam logic [3:0] IDX_WINDOW_Y_MAX = 4'hB;
  localparam logic [3:0] IDX_PIXEL_DATA_PORT = 4'hC;
  // data_access_control fields
  localparam int DAC_SCAN_AXIS_BIT = 0;
  localparam int DAC_X_STEP_DIRECTION_BIT = 1;
  localparam int DAC_Y_STEP_DIRECTION_BIT = 2;
  localparam int DAC_BURST_WRITE_ENABLE_BIT = 6;
  // control_one fields
  localparam int CTL_SEGMENT_ORDER_BIT = 0;
  localparam int CTL_WINDOW_ACCESS_ENABLE_BIT = 1;
  // reset values
  localparam logic [7:0] DATA_ACCESS_CONTROL_RESET = 8'h00;
  localparam logic [7:0] CONTROL_ONE_RESET = 8'h00;
  localparam logic [7:0] POINTER_RESET = 8'h00;
  // address limits of the display ram
  localparam logic [7:0] X_FIRST = 8'h00;
  localparam logic [7:0] X_LAST = 8'h83;
  localparam logic [7:0] Y_FIRST = 8'h00;
  localparam logic [7:0] Y_LAST = 8'hAF;
  localparam logic [8:0] COLUMN_LAST = 9'h18B;
  // burst staging geometry
  localparam int PIXEL_WIDTH = 16;
  localparam int BURST_WORDS = 4;
endpackage

//--- hw/drw_addr_step.sv
// pointer stepper: next x/y address with scan axis, direction and window wrap
`timescale 1ns/1ps
`default_nettype none
module drw_addr_step (
  input wire logic [7:0] x_cur,
  input wire logic [7:0] y_cur,
  input wire logic scan_axis,
  input wire logic x_step_direction,
  input wire logic y_step_direction,
  input wire logic window_access_enable,
  input wire logic [7:0] window_x_min,
  input wire logic [7:0] window_x_max,
  input wire logic [7:0] window_y_min,
  input wire logic [7:0] window_y_max,
  output logic [7:0] x_next,
  output logic [7:0] y_next
);
  logic [7:0] x_lo;
  logic [7:0] x_hi;
  logic [7:0] y_lo;
  logic [7:0] y_hi;
  logic [7:0] x_adv;
  logic [7:0] y_adv;
  logic x_wrap;
  logic y_wrap;

  // bounds are the window in window mode, the full memory otherwise
  always_comb begin
    x_lo = window_access_enable ? window_x_min : drw_pkg::X_FIRST;
    x_hi = window_access_enable ? window_x_max : drw_pkg::X_LAST;
    y_lo = window_access_enable ? window_y_min : drw_pkg::Y_FIRST;
    y_hi = window_access_enable ? window_y_max : drw_pkg::Y_LAST;
  end

  // one step on each axis with wrap at the bounds
  always_comb begin
    x_wrap = x_step_direction ? (x_cur == x_lo) : (x_cur == x_hi);
    y_wrap = y_step_direction ? (y_cur == y_lo) : (y_cur == y_hi);
    if (x_step_direction) begin
      x_adv = x_wrap ? x_hi : x_cur - 8'h01;
    end else begin
      x_adv = x_wrap ? x_lo : x_cur + 8'h01;
    end
    if (y_step_direction) begin
      y_adv = y_wrap ? y_hi : y_cur - 8'h01;
    end else begin
      y_adv = y_wrap ? y_lo : y_cur + 8'h01;
    end
  end

  // axis choice: the scanned axis steps, the other steps on its wrap
  always_comb begin
    if (scan_axis) begin
      y_next = y_adv;
      x_next = y_wrap ? x_adv : x_cur;
    end else begin
      x_next = x_adv;
      y_next = x_wrap ? y_adv : y_cur;
    end
  end
endmodule // drw_addr_step
`default_nettype wire

//--- hw/drw_top.sv
// display ram address writer: host register port, pointers, burst staging, segment map
//
// Summary of operation
// - axis bit 1: y steps each write
// - y up past AFH: step x, y=00H
// - y down past 00H: step x, y=AFH
// - axis bit 0 steps x, 1 steps y
// - x direction 0 adds, 1 subtracts
// - y direction 0 adds, 1 subtracts
// - x wraps 83H/00H and steps y
// - segment order bit reverses column mapping
// - window mode confines access to rectangle
// - window mode keeps scan, starts at pointers
// - burst bit stages pixels in buffer
// - commit only after four pixels collected
// - next pixels accepted during commit
// - partial group kept, filling resumes after
// - reselect then pixel port clears buffer
`timescale 1ns/1ps
`default_nettype none
module drw_top #(
  parameter int PIXEL_WIDTH = drw_pkg::PIXEL_WIDTH,
  parameter int BURST_WORDS = drw_pkg::BURST_WORDS
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic cs_n,
  input wire logic rs,
  input wire logic wr,
  input wire logic rd,
  input wire logic [15:0] din,
  input wire logic [8:0] scan_column,
  output logic [15:0] rdata,
  output logic ram_we,
  output logic ram_burst,
  output logic [7:0] ram_x,
  output logic [7:0] ram_y,
  output logic [PIXEL_WIDTH*BURST_WORDS-1:0] ram_wdata,
  output logic [8:0] segment_output,
  output logic [1:0] burst_fill
);
  localparam int CW = $clog2(BURST_WORDS);
  localparam logic [CW-1:0] SLOT_LAST = CW'(BURST_WORDS - 1);

  // refuse shapes the staging logic cannot serve
  generate
    if (PIXEL_WIDTH != 16 || BURST_WORDS != 4) begin : g_bad_shape
      $error("drw_top supports 16-bit pixels in groups of four only");
    end
  endgenerate

  // true when the selected index matches a register code
  function automatic logic index_is(input logic [3:0] sel, input logic [3:0] code);
    index_is = (sel == code);
  endfunction

  logic [3:0] index_reg;
  logic [7:0] data_access_control_reg;
  logic [7:0] control_one_reg;
  logic [7:0] x_pointer_reg;
  logic [7:0] y_pointer_reg;
  logic [7:0] window_x_min_reg;
  logic [7:0] window_x_max_reg;
  logic [7:0] window_y_min_reg;
  logic [7:0] window_y_max_reg;
  logic [PIXEL_WIDTH-1:0] slot_reg [BURST_WORDS];
  logic [CW-1:0] fill_reg;
  logic [7:0] group_x_reg;
  logic [7:0] group_y_reg;
  logic cs_n_q_reg;
  logic reselect_reg;
  logic [15:0] rdata_reg;
  logic ram_we_reg;
  logic ram_burst_reg;
  logic [7:0] ram_x_reg;
  logic [7:0] ram_y_reg;
  logic [PIXEL_WIDTH*BURST_WORDS-1:0] ram_wdata_reg;
  logic [8:0] segment_output_reg;

  logic host_wr;
  logic host_rd;
  logic index_wr;
  logic data_wr;
  logic pixel_wr;
  logic burst_on;
  logic window_on;
  logic group_done;
  logic buffer_clear;
  logic [7:0] x_next;
  logic [7:0] y_next;
  logic [PIXEL_WIDTH*BURST_WORDS-1:0] commit_data;

  // host strobes only count while selected
  always_comb begin
    host_wr = wr & ~cs_n;
    host_rd = rd & ~cs_n;
    index_wr = host_wr & ~rs;
    data_wr = host_wr & rs;
    pixel_wr = data_wr & index_is(index_reg, drw_pkg::IDX_PIXEL_DATA_PORT);
    burst_on = data_access_control_reg[drw_pkg::DAC_BURST_WRITE_ENABLE_BIT];
    window_on = control_one_reg[drw_pkg::CTL_WINDOW_ACCESS_ENABLE_BIT];
    group_done = pixel_wr & burst_on & (fill_reg == SLOT_LAST);
    buffer_clear = index_wr & reselect_reg & index_is(din[3:0], drw_pkg::IDX_PIXEL_DATA_PORT);
  end

  // next pointer position after a pixel write
  drw_addr_step u_step (
    .x_cur(x_pointer_reg),
    .y_cur(y_pointer_reg),
    .scan_axis(data_access_control_reg[drw_pkg::DAC_SCAN_AXIS_BIT]),
    .x_step_direction(data_access_control_reg[drw_pkg::DAC_X_STEP_DIRECTION_BIT]),
    .y_step_direction(data_access_control_reg[drw_pkg::DAC_Y_STEP_DIRECTION_BIT]),
    .window_access_enable(window_on),
    .window_x_min(window_x_min_reg),
    .window_x_max(window_x_max_reg),
    .window_y_min(window_y_min_reg),
    .window_y_max(window_y_max_reg),
    .x_next(x_next),
    .y_next(y_next)
  );

  // index register selects the target of data writes
  always_ff @(posedge clk) begin
    if (reset) begin
      index_reg <= drw_pkg::IDX_CONTROL_ONE;
    end else if (index_wr) begin
      index_reg <= din[3:0];
    end
  end

  // mode registers
  always_ff @(posedge clk) begin
    if (reset) begin
      data_access_control_reg <= drw_pkg::DATA_ACCESS_CONTROL_RESET;
      control_one_reg <= drw_pkg::CONTROL_ONE_RESET;
    end else if (data_wr) begin
      if (index_is(index_reg, drw_pkg::IDX_DATA_ACCESS_CONTROL)) begin
        data_access_control_reg <= din[7:0];
      end
      if (index_is(index_reg, drw_pkg::IDX_CONTROL_ONE)) begin
        control_one_reg <= din[7:0];
      end
    end
  end

  // window bound registers
  always_ff @(posedge clk) begin
    if (reset) begin
      window_x_min_reg <= drw_pkg::X_FIRST;
      window_x_max_reg <= drw_pkg::X_LAST;
      window_y_min_reg <= drw_pkg::Y_FIRST;
      window_y_max_reg <= drw_pkg::Y_LAST;
    end else if (data_wr) begin
      if (index_is(index_reg, drw_pkg::IDX_WINDOW_X_MIN)) begin
        window_x_min_reg <= din[7:0];
      end
      if (index_is(index_reg, drw_pkg::IDX_WINDOW_X_MAX)) begin
        window_x_max_reg <= din[7:0];
      end
      if (index_is(index_reg, drw_pkg::IDX_WINDOW_Y_MIN)) begin
        window_y_min_reg <= din[7:0];
      end
      if (index_is(index_reg, drw_pkg::IDX_WINDOW_Y_MAX)) begin
        window_y_max_reg <= din[7:0];
      end
    end
  end

  // pointers: loaded by the host, stepped by every pixel write
  always_ff @(posedge clk) begin
    if (reset) begin
      x_pointer_reg <= drw_pkg::POINTER_RESET;
      y_pointer_reg <= drw_pkg::POINTER_RESET;
    end else if (pixel_wr) begin
      x_pointer_reg <= x_next;
      y_pointer_reg <= y_next;
    end else if (data_wr) begin
      if (index_is(index_reg, drw_pkg::IDX_X_POINTER)) begin
        x_pointer_reg <= din[7:0];
      end
      if (index_is(index_reg, drw_pkg::IDX_Y_POINTER)) begin
        y_pointer_reg <= din[7:0];
      end
    end
  end

  // a deselect with burst on arms the clear; the next index write performs it if it selects the pixel port
  always_ff @(posedge clk) begin
    if (reset) begin
      cs_n_q_reg <= 1'b1;
      reselect_reg <= 1'b0;
    end else begin
      cs_n_q_reg <= cs_n;
      if (cs_n & ~cs_n_q_reg & burst_on) begin
        reselect_reg <= 1'b1;
      end else if (index_wr) begin
        reselect_reg <= 1'b0;
      end
    end
  end

  // staging slots, one register per pixel word
  genvar gi;
  generate
    for (gi = 0; gi < BURST_WORDS; gi++) begin : g_slot
      always_ff @(posedge clk) begin
        if (reset) begin
          slot_reg[gi] <= '0;
        end else if (pixel_wr & burst_on & (fill_reg == CW'(gi))) begin
          slot_reg[gi] <= din;
        end
      end
    end
  endgenerate

  // fill count and the address of the group's first pixel
  always_ff @(posedge clk) begin
    if (reset) begin
      fill_reg <= '0;
      group_x_reg <= drw_pkg::POINTER_RESET;
      group_y_reg <= drw_pkg::POINTER_RESET;
    end else if (buffer_clear) begin
      fill_reg <= '0;
    end else if (pixel_wr & burst_on) begin
      fill_reg <= group_done ? '0 : fill_reg + CW'(1);
      if (fill_reg == '0) begin
        group_x_reg <= x_pointer_reg;
        group_y_reg <= y_pointer_reg;
      end
    end
  end

  // group word: stored slots plus the word arriving now in the last slot
  always_comb begin
    commit_data = '0;
    for (int i = 0; i < BURST_WORDS - 1; i++) begin
      commit_data[i*PIXEL_WIDTH +: PIXEL_WIDTH] = slot_reg[i];
    end
    commit_data[(BURST_WORDS-1)*PIXEL_WIDTH +: PIXEL_WIDTH] = din;
  end

  // ram write port: single pixel writes directly, bursts commit whole groups
  always_ff @(posedge clk) begin
    if (reset) begin
      ram_we_reg <= 1'b0;
      ram_burst_reg <= 1'b0;
      ram_x_reg <= drw_pkg::POINTER_RESET;
      ram_y_reg <= drw_pkg::POINTER_RESET;
      ram_wdata_reg <= '0;
    end else if (pixel_wr & ~burst_on) begin
      ram_we_reg <= 1'b1;
      ram_burst_reg <= 1'b0;
      ram_x_reg <= x_pointer_reg;
      ram_y_reg <= y_pointer_reg;
      ram_wdata_reg <= {{(PIXEL_WIDTH*(BURST_WORDS-1)){1'b0}}, din};
    end else if (group_done) begin
      ram_we_reg <= 1'b1;
      ram_burst_reg <= 1'b1;
      ram_x_reg <= (fill_reg == '0) ? x_pointer_reg : group_x_reg;
      ram_y_reg <= (fill_reg == '0) ? y_pointer_reg : group_y_reg;
      ram_wdata_reg <= commit_data;
    end else begin
      ram_we_reg <= 1'b0;
    end
  end

  // register readback; the pixel port is write only
  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_reg <= 16'h0000;
    end else if (host_rd & rs) begin
      case (index_reg)
        drw_pkg::IDX_CONTROL_ONE: rdata_reg <= {8'h00, control_one_reg};
        drw_pkg::IDX_DATA_ACCESS_CONTROL: rdata_reg <= {8'h00, data_access_control_reg};
        drw_pkg::IDX_X_POINTER: rdata_reg <= {8'h00, x_pointer_reg};
        drw_pkg::IDX_Y_POINTER: rdata_reg <= {8'h00, y_pointer_reg};
        drw_pkg::IDX_WINDOW_X_MIN: rdata_reg <= {8'h00, window_x_min_reg};
        drw_pkg::IDX_WINDOW_X_MAX: rdata_reg <= {8'h00, window_x_max_reg};
        drw_pkg::IDX_WINDOW_Y_MIN: rdata_reg <= {8'h00, window_y_min_reg};
        drw_pkg::IDX_WINDOW_Y_MAX: rdata_reg <= {8'h00, window_y_max_reg};
        default: rdata_reg <= 16'h0000;
      endcase
    end
  end

  // column to segment mapping, reversed by the segment order bit
  always_ff @(posedge clk) begin
    if (reset) begin
      segment_output_reg <= 9'h000;
    end else if (control_one_reg[drw_pkg::CTL_SEGMENT_ORDER_BIT]) begin
      segment_output_reg <= drw_pkg::COLUMN_LAST - scan_column;
    end else begin
      segment_output_reg <= scan_column;
    end
  end

  // outputs straight from flip-flops
  always_comb begin
    rdata = rdata_reg;
    ram_we = ram_we_reg;
    ram_burst = ram_burst_reg;
    ram_x = ram_x_reg;
    ram_y = ram_y_reg;
    ram_wdata = ram_wdata_reg;
    segment_output = segment_output_reg;
    burst_fill = 2'(fill_reg);
  end
endmodule // drw_top
`default_nettype wire

//--- sim/drw_checker_sva.sv
// checker: port assertions of the display ram address writer
`timescale 1ns/1ps
`default_nettype none
module drw_checker (
  input wire logic clk,
  input wire logic reset,
  input wire logic cs_n,
  input wire logic rs,
  input wire logic wr,
  input wire logic [15:0] din,
  input wire logic [8:0] scan_column,
  input wire logic ram_we,
  input wire logic ram_burst,
  input wire logic [7:0] ram_x,
  input wire logic [7:0] ram_y,
  input wire logic [8:0] segment_output,
  input wire logic [1:0] burst_fill
);
  logic [3:0] idx_reg;
  logic [7:0] dac_reg;
  logic [7:0] ctl_reg;
  wire hw = !cs_n && wr;
  wire pw = hw && rs && idx_reg == drw_pkg::IDX_PIXEL_DATA_PORT;
  wire bst = dac_reg[drw_pkg::DAC_BURST_WRITE_ENABLE_BIT];
  wire lin = !bst && !ctl_reg[drw_pkg::CTL_WINDOW_ACCESS_ENABLE_BIT];
  // shadow of index and mode registers
  always_ff @(posedge clk) begin
    if (reset) begin
      idx_reg <= 4'h0;
      dac_reg <= 8'h00;
      ctl_reg <= 8'h00;
    end else if (hw && !rs) begin
      idx_reg <= din[3:0];
    end else if (hw && idx_reg == drw_pkg::IDX_DATA_ACCESS_CONTROL) begin
      dac_reg <= din[7:0];
    end else if (hw && idx_reg == drw_pkg::IDX_CONTROL_ONE) begin
      ctl_reg <= din[7:0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // two back-to-back ram writes, the first under condition c
  sequence s_pair(c);
    c && ram_we ##1 ram_we;
  endsequence
  // deselect with burst on, then pixel port chosen again
  sequence s_desel;
    bst && $rose(cs_n);
  endsequence
  sequence s_sel_port;
    hw && !rs && din[3:0] == drw_pkg::IDX_PIXEL_DATA_PORT;
  endsequence
  AST_SINGLE: assert property (
    pw && !bst |=> ram_we && !ram_burst) else $error("single pixel write missing");
  AST_FILL: assert property (
    pw && bst && burst_fill != 2'h3 |=> !ram_we && burst_fill == $past(burst_fill) + 2'h1)
    else $error("burst staging count wrong");
  AST_COMMIT: assert property (
    pw && bst && burst_fill == 2'h3 |=> ram_we && ram_burst && burst_fill == 2'h0)
    else $error("burst group not committed");
  AST_Y_UP: assert property (
    s_pair(lin && dac_reg[2:0] == 3'h1 && ram_y != 8'hAF) |-> ram_y == $past(ram_y) + 8'h01 && $stable(ram_x))
    else $error("y step wrong");
  AST_Y_WRAP: assert property (
    s_pair(lin && dac_reg[2:0] == 3'h1 && ram_y == 8'hAF) |->
      ram_y == 8'h00 && ram_x == ($past(ram_x) == 8'h83 ? 8'h00 : $past(ram_x) + 8'h01))
    else $error("y wrap wrong");
  AST_X_WRAP: assert property (
    s_pair(lin && dac_reg[2:0] == 3'h0 && ram_x == 8'h83) |->
      ram_x == 8'h00 && ram_y == ($past(ram_y) == 8'hAF ? 8'h00 : $past(ram_y) + 8'h01))
    else $error("x wrap wrong");
  AST_CLEAR: assert property (
    s_desel ##1 s_sel_port |=> burst_fill == 2'h0) else $error("staging not cleared");
  AST_SEG: assert property (
    !$past(reset) |-> segment_output == ($past(ctl_reg[0]) ? 9'h18B - $past(scan_column) : $past(scan_column)))
    else $error("segment map wrong");
endmodule // drw_checker
bind drw_top drw_checker chk (.clk(clk), .reset(reset), .cs_n(cs_n), .rs(rs), .wr(wr), .din(din),
  .scan_column(scan_column), .ram_we(ram_we), .ram_burst(ram_burst), .ram_x(ram_x), .ram_y(ram_y),
  .segment_output(segment_output), .burst_fill(burst_fill));
`default_nettype wire

//--- sim/drw_host_model.sv
// host model: drives the register port of the display ram writer
`timescale 1ns/1ps
`default_nettype none
module drw_host_model (
  input wire logic clk,
  output logic cs_n,
  output logic rs,
  output logic wr,
  output logic rd,
  output logic [15:0] din
);
  // idle, deselected at time zero
  initial begin
    cs_n = 1'b1;
    rs = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    din = 16'h0000;
  end
  // one write, taken at the next rising edge
  task automatic put(input logic r, input logic [15:0] d);
    @(posedge clk);
    cs_n <= 1'b0;
    rs <= r;
    wr <= 1'b1;
    rd <= 1'b0;
    din <= d;
  endtask
  // one read strobe on the data port
  task automatic get();
    @(posedge clk);
    cs_n <= 1'b0;
    rs <= 1'b1;
    wr <= 1'b0;
    rd <= 1'b1;
  endtask
  // strobes off; released data lines show the inverse pattern
  task automatic idle(input logic sel);
    @(posedge clk);
    cs_n <= !sel;
    wr <= 1'b0;
    rd <= 1'b0;
    din <= ~din;
  endtask
endmodule // drw_host_model
`default_nettype wire

//--- sim/drw_top_bench.sv
// testbench: random and corner pixel traffic through the display ram writer
`timescale 1ns/1ps
`default_nettype none
module drw_top_bench;
  logic clk, reset, cs_n, rs, wr, rd, ram_we, ram_burst;
  logic [15:0] din, rdata;
  logic [15:0] seed = 16'h003A;
  logic [8:0] scan_column;
  logic [8:0] segment_output;
  logic [7:0] ram_x, ram_y, gx, gy;
  logic [7:0] dac = 8'h00, ctl = 8'h00, mx = 8'h00, my = 8'h00;
  logic [7:0] wx0 = 8'h00, wx1 = 8'h83, wy0 = 8'h00, wy1 = 8'hAF;
  logic [63:0] ram_wdata, stage;
  logic [1:0] burst_fill;
  logic [80:0] exq[$], got[$];
  int fill = 0, n_fail = 0, checks = 0, cyc = 0;
  drw_top DUT (.clk(clk), .reset(reset), .cs_n(cs_n), .rs(rs), .wr(wr), .rd(rd), .din(din),
    .scan_column(scan_column), .rdata(rdata), .ram_we(ram_we), .ram_burst(ram_burst), .ram_x(ram_x),
    .ram_y(ram_y), .ram_wdata(ram_wdata), .segment_output(segment_output), .burst_fill(burst_fill));
  drw_host_model host (.clk(clk), .cs_n(cs_n), .rs(rs), .wr(wr), .rd(rd), .din(din));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // cycle count, column sweep, hang limit and ram write capture
  always @(posedge clk) begin
    cyc <= cyc + 1;
    scan_column <= 9'((cyc * 37) % 396);
    if (ram_we === 1'b1) got.push_back({ram_burst, ram_x, ram_y, ram_wdata});
    if (cyc == 4000) begin
      n_fail++;
      close_out();
    end
  end
  function automatic logic [15:0] nxt();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed;
  endfunction
  function automatic logic [7:0] adv(input logic [7:0] v, input logic d, input logic [7:0] l, input logic [7:0] h);
    return d ? (v == l ? h : v - 8'h01) : (v == h ? l : v + 8'h01);
  endfunction
  task automatic cmp_w(input logic [80:0] e, input logic [80:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value at %0t: ram write %h expected %h", $time, g, e);
    end
  endtask
  task automatic cmp_r(input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value at %0t: read %h expected %h", $time, g, e);
    end
  endtask
  // segment index one cycle after a settled column, reversed when the order bit is set
  task automatic seg_chk();
    logic [8:0] c;
    @(negedge clk);
    c = scan_column;
    @(negedge clk);
    cmp_r(16'(ctl[0] ? drw_pkg::COLUMN_LAST - c : c), 16'(segment_output));
  endtask
  task automatic chk_q();
    repeat (3) @(posedge clk);
    while (exq.size() > 0) cmp_w(exq.pop_front(), got.size() > 0 ? got.pop_front() : 'x);
    cmp_r(16'h0000, 16'(got.size()));
    got.delete();
  endtask
  task automatic reg_w(input logic [3:0] i, input logic [7:0] v);
    host.put(1'b0, {12'h000, i});
    host.put(1'b1, {8'h00, v});
    case (i)
      drw_pkg::IDX_CONTROL_ONE: ctl = v;
      drw_pkg::IDX_DATA_ACCESS_CONTROL: dac = v;
      drw_pkg::IDX_X_POINTER: mx = v;
      drw_pkg::IDX_Y_POINTER: my = v;
      drw_pkg::IDX_WINDOW_X_MIN: wx0 = v;
      drw_pkg::IDX_WINDOW_X_MAX: wx1 = v;
      drw_pkg::IDX_WINDOW_Y_MIN: wy0 = v;
      drw_pkg::IDX_WINDOW_Y_MAX: wy1 = v;
      default: ;
    endcase
  endtask
  task automatic rd_r(input logic [3:0] i, input logic [15:0] e);
    host.put(1'b0, {12'h000, i});
    host.get();
    host.idle(1'b1);
    repeat (2) @(posedge clk);
    cmp_r(e, rdata);
  endtask
  // pixel write plus expected ram write and pointer step
  task automatic pix(input logic [15:0] d);
    logic [7:0] xl, xh, yl, yh;
    logic w;
    host.put(1'b1, d);
    if (dac[6]) begin
      if (fill == 0) {gx, gy} = {mx, my};
      stage[fill*16 +: 16] = d;
      fill++;
      if (fill == 4) exq.push_back({1'b1, gx, gy, stage});
      if (fill == 4) fill = 0;
    end else exq.push_back({1'b0, mx, my, 48'h0, d});
    {xl, xh} = ctl[1] ? {wx0, wx1} : {drw_pkg::X_FIRST, drw_pkg::X_LAST};
    {yl, yh} = ctl[1] ? {wy0, wy1} : {drw_pkg::Y_FIRST, drw_pkg::Y_LAST};
    w = dac[0] ? my == (dac[2] ? yl : yh) : mx == (dac[1] ? xl : xh);
    if (dac[0] && w) mx = adv(mx, dac[1], xl, xh);
    if (dac[0]) my = adv(my, dac[2], yl, yh);
    if (!dac[0] && w) my = adv(my, dac[2], yl, yh);
    if (!dac[0]) mx = adv(mx, dac[1], xl, xh);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    reset = 1'b1;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    rd_r(4'h5, {8'h00, drw_pkg::DATA_ACCESS_CONTROL_RESET});
    rd_r(4'hD, 16'h0000);
    reg_w(4'h5, 8'h07);
    rd_r(4'h5, 16'h0007);
    rd_r(4'hC, 16'h0000);
    $display("test registers done");
    for (int m = 0; m < 8; m++) begin
      reg_w(4'h5, 8'(m));
      reg_w(4'h6, m[1] ? 8'h01 : 8'h82);
      reg_w(4'h7, m[2] ? 8'h01 : 8'hAE);
      host.put(1'b0, 16'h000C);
      repeat (4) pix(nxt());
      host.idle(1'b1);
      chk_q();
      seg_chk();
    end
    $display("test scan modes done");
    reg_w(4'h8, 8'h10);
    reg_w(4'h9, 8'h12);
    reg_w(4'hA, 8'h20);
    reg_w(4'hB, 8'h21);
    reg_w(4'h0, 8'h03);
    for (int m = 0; m < 4; m++) begin
      reg_w(4'h5, {5'h00, m[1], m[1], m[0]});
      reg_w(4'h6, 8'h11);
      reg_w(4'h7, 8'h20);
      host.put(1'b0, 16'h000C);
      repeat (7) pix(nxt());
      host.idle(1'b1);
      chk_q();
      seg_chk();
    end
    reg_w(4'h0, 8'h00);
    $display("test window done");
    reg_w(4'h5, 8'h40);
    reg_w(4'h6, 8'h04);
    reg_w(4'h7, 8'h05);
    host.put(1'b0, 16'h000C);
    repeat (10) pix(nxt());
    host.idle(1'b1);
    chk_q();
    cmp_r(16'h0002, 16'(burst_fill));
    host.put(1'b0, 16'h000C);
    repeat (2) pix(nxt());
    host.idle(1'b1);
    chk_q();
    host.put(1'b0, 16'h000C);
    pix(nxt());
    host.idle(1'b0);
    host.put(1'b0, 16'h000C);
    fill = 0;
    reg_w(4'h6, 8'h08);
    reg_w(4'h7, 8'h06);
    host.put(1'b0, 16'h000C);
    repeat (4) pix(nxt());
    host.idle(1'b1);
    chk_q();
    $display("test burst done");
    close_out();
  end
endmodule // drw_top_bench
`default_nettype wire
